// ===== logic/cdic_pkg.sv
package cdic_pkg;
   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_EXT = 4;
   localparam int NUM_FLAGS = 8;
   localparam int SUB_W = 8;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_FLAG = 8'h00;
   localparam logic [7:0] OFS_ENABLE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_DMACTL = 8'h0c;
   localparam logic [7:0] OFS_PEND = 8'h10;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int STAT_GIE_BIT = 0;
   localparam int STAT_EDGE_BIT = 1;
   localparam int IE_DMA_LSB = 16;
   localparam int DMA_FIELD_W = 4;
   localparam int DMA_START_LSB = 0;
   localparam int DMA_SYNC_LSB = 2;
   localparam int DMA_RST_BIT = 31;
   localparam logic [1:0] DMA_START_RST = 2'h0;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [1:0] DB_SLOTS = 2'h3;
   localparam logic [5:0] VEC_OFS = 6'h01;
   // ---------------------------------------------------------------
   // Dispatch states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      CD_IDLE, CD_RECOG, CD_CLEAR, CD_VEC, CD_PUSH, CD_FILL1, CD_FILL2, CD_FILL3, CD_EXEC
   } cdic_state_t;
   // ---------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------
   function automatic logic [2:0] cdicLowest(input logic [NUM_FLAGS-1:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NUM_FLAGS - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction
   function automatic logic [NUM_FLAGS-1:0] cdicOneHot(input logic [2:0] idx);
      return 8'h01 << idx;
   endfunction
endpackage

// ===== logic/cdic_pin_sync.sv
`timescale 1ns/1ps
module cdic_pin_sync
   import cdic_pkg::*;
#(
   parameter int N = NUM_EXT
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pins and mode
   input wire logic [N-1:0] extIrqN,
   input wire logic edgeMode,
   // Flag set requests
   output logic [N-1:0] setReq
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
   } cdic_sync_t;
   cdic_sync_t st_q, st_d;
   // ---------------------------------------------------------------
   // Synchroniser chain
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      st_d.s1 = extIrqN;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= '1;
      end
      else
      begin
         st_q <= st_d;
      end
   end
   // Edge wants a high-to-low step, level wants low
   assign setReq = edgeMode ? (st_q.s3 & ~st_q.s2) : ~st_q.s2;
endmodule // cdic_pin_sync

// ===== logic/cdic_irq_ack_strobe_ctl.sv
`timescale 1ns/1ps
module cdic_irq_ack_strobe_ctl
   import cdic_pkg::*;
#(
   parameter int AW = 24
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Acknowledge instruction
   input wire logic iackExec,
   input wire logic iackExtMem,
   input wire logic [AW-1:0] iackAddr,
   input wire logic dummyRdDone,
   // External side
   output logic irqAckStrobeN,
   output logic dummyRdReq,
   output logic [AW-1:0] dummyRdAddr
);
   typedef struct packed {
      logic busy;
      logic strobeN;
      logic rdReq;
      logic [AW-1:0] addr;
   } cdic_irq_ack_strobe_t;
   cdic_irq_ack_strobe_t st_q, st_d;
   always_comb
   begin
      st_d = st_q;
      if (!st_q.busy && iackExec && iackExtMem)
      begin
         st_d.busy = 1'b1;
         st_d.strobeN = 1'b0;
         st_d.rdReq = 1'b1;
         st_d.addr = iackAddr;
      end
      else if (st_q.busy && dummyRdDone)
      begin
         st_d.busy = 1'b0;
         st_d.strobeN = 1'b1;
         st_d.rdReq = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= '{busy: 1'b0, strobeN: 1'b1, rdReq: 1'b0, addr: '0};
      end
      else
      begin
         st_q <= st_d;
      end
   end
   assign irqAckStrobeN = st_q.strobeN;
   assign dummyRdReq = st_q.rdReq;
   assign dummyRdAddr = st_q.addr;
   a_irq_ack_strobe_strobe: assert property (@(posedge clk) disable iff (!nrst)
      (!st_q.busy && iackExec && iackExtMem) |=>
      (!irqAckStrobeN && dummyRdReq && dummyRdAddr == $past(iackAddr)))
      else $error("acknowledge strobe or dummy read missing");
endmodule // cdic_irq_ack_strobe_ctl

// ===== logic/cdic_top.sv
`timescale 1ns/1ps
module cdic_top
   import cdic_pkg::*;
#(
   parameter int AW = 24,
   parameter int NUM_CH = 2,
   parameter bit EDGE_CAPABLE = 1'b1
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt sources
   input wire logic [NUM_EXT-1:0] extIrqN,
   input wire logic [NUM_FLAGS-NUM_EXT-1:0] intIrq,
   // Pipeline status
   input wire logic fetchValid,
   input wire logic fetchFirst,
   input wire logic fetchStall,
   input wire logic repeatSingleInstr,
   input wire logic delayedBranch,
   input wire logic instrDone,
   input wire logic [AW-1:0] fetchAddr,
   input wire logic [AW-1:0] nextFetchAddr,
   input wire logic returnFromIrq,
   input wire logic condReturnFromIrq,
   // Dispatch to pipeline
   output logic flushFetch,
   output logic vecRdReq,
   output logic [5:0] vecIndex,
   input wire logic [AW-1:0] vecData,
   output logic pushReq,
   output logic [AW-1:0] pushData,
   output logic pcLoad,
   output logic [AW-1:0] pcLoadAddr,
   output logic isrExec,
   // Acknowledge instruction
   input wire logic iackExec,
   input wire logic iackExtMem,
   input wire logic [AW-1:0] iackAddr,
   input wire logic dummyRdDone,
   output logic irqAckStrobeN,
   output logic dummyRdReq,
   output logic [AW-1:0] dummyRdAddr,
   // DMA channels
   input wire logic dmaReset,
   input wire logic [NUM_CH-1:0] dmaTaken,
   output logic [NUM_CH-1:0] dmaSyncReq
);
   typedef struct packed {
      cdic_state_t state;
      logic [1:0] dbCnt;
      logic [NUM_FLAGS-1:0] flag;
      logic [31:0] ien;
      logic global_irq_enable;
      logic edgeMode;
      logic [31:0] dmaCtl;
      logic [NUM_CH*SUB_W-1:0] pend;
      logic [2:0] ackIdx;
      logic [5:0] vecIdx;
      logic [AW-1:0] retAddr;
      logic [AW-1:0] pcAddr;
      logic flush;
      logic vecRd;
      logic push;
      logic pcLd;
      logic isr;
      logic [31:0] rdata;
      logic rdy;
      logic err;
      logic [NUM_CH-1:0] syncReq;
   } cdic_regs_t;
   cdic_regs_t st_q, st_d;
   logic [NUM_EXT-1:0] extSet;
   logic [NUM_FLAGS-1:0] setV, ackClr, dmaClr, levelMask, cand, hit;
   logic wrEn, rdEn, accept, edgeEff, mapped;
   // ---------------------------------------------------------------
   // Pin synchronisers and acknowledge strobe
   // ---------------------------------------------------------------
   cdic_pin_sync #(.N(NUM_EXT)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .extIrqN(extIrqN),
      .edgeMode(edgeEff),
      .setReq(extSet)
   );
   cdic_irq_ack_strobe_ctl #(.AW(AW)) u_irq_ack_strobe (
      .clk(clk),
      .nrst(nrst),
      .iackExec(iackExec),
      .iackExtMem(iackExtMem),
      .iackAddr(iackAddr),
      .dummyRdDone(dummyRdDone),
      .irqAckStrobeN(irqAckStrobeN),
      .dummyRdReq(dummyRdReq),
      .dummyRdAddr(dummyRdAddr)
   );
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   assign edgeEff = EDGE_CAPABLE && st_q.edgeMode;
   always_comb
   begin
      st_d = st_q;
      wrEn = psel && penable && st_q.rdy && pwrite;
      rdEn = psel && !penable;
      mapped = (paddr == OFS_FLAG) || (paddr == OFS_ENABLE) || (paddr == OFS_STATUS) ||
         (paddr == OFS_DMACTL) || (paddr == OFS_PEND);
      setV = {intIrq, extSet};
      levelMask = {{(NUM_FLAGS-NUM_EXT){1'b0}}, {NUM_EXT{!edgeEff}}};
      ackClr = (st_q.state == CD_CLEAR) ? cdicOneHot(st_q.ackIdx) : '0;
      // DMA latching, independent of global enable
      dmaClr = '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
         hit = st_q.flag & st_q.ien[IE_DMA_LSB + SUB_W*c +: SUB_W];
         if (st_q.dmaCtl[DMA_FIELD_W*c + DMA_START_LSB +: 2] == DMA_START_RST)
         begin
            hit = '0;
         end
         dmaClr = dmaClr | hit;
         if (dmaTaken[c])
         begin
            st_d.pend[SUB_W*c +: SUB_W] = st_q.pend[SUB_W*c +: SUB_W] &
               ~cdicOneHot(cdicLowest(st_q.pend[SUB_W*c +: SUB_W]));
         end
         st_d.pend[SUB_W*c +: SUB_W] = st_d.pend[SUB_W*c +: SUB_W] | hit;
         st_d.syncReq[c] = (st_q.dmaCtl[DMA_FIELD_W*c + DMA_SYNC_LSB +: 2] != 2'h0) &&
            (|st_d.pend[SUB_W*c +: SUB_W]);
      end
      if (dmaReset || (wrEn && paddr == OFS_DMACTL && pwdata[DMA_RST_BIT]))
      begin
         st_d.pend = '0;
         st_d.syncReq = '0;
      end
      // Flags: pulses and edges beat a clear, a still-low level loses once
      st_d.flag = (st_q.flag & ~(ackClr | dmaClr)) |
         (setV & ~((ackClr | dmaClr) & levelMask));
      if (wrEn && paddr == OFS_FLAG)
      begin
         st_d.flag = pwdata[NUM_FLAGS-1:0];
      end
      // Register writes
      if (wrEn && paddr == OFS_ENABLE)
      begin
         st_d.ien = pwdata;
      end
      if (wrEn && paddr == OFS_DMACTL)
      begin
         st_d.dmaCtl = {1'b0, pwdata[30:0]};
      end
      if (wrEn && paddr == OFS_STATUS)
      begin
         st_d.global_irq_enable = pwdata[STAT_GIE_BIT];
         st_d.edgeMode = EDGE_CAPABLE && pwdata[STAT_EDGE_BIT];
      end
      if (returnFromIrq || condReturnFromIrq)
      begin
         st_d.global_irq_enable = 1'b1;
      end
      if (st_q.state == CD_CLEAR)
      begin
         st_d.global_irq_enable = 1'b0;
      end
      // Delayed-branch shadow
      if (delayedBranch)
      begin
         st_d.dbCnt = DB_SLOTS;
      end
      else if (instrDone && st_q.dbCnt != 2'h0)
      begin
         st_d.dbCnt = st_q.dbCnt - 2'h1;
      end
      // Acceptance
      cand = st_q.flag & st_q.ien[NUM_FLAGS-1:0] & {NUM_FLAGS{st_q.global_irq_enable}};
      accept = (st_q.state == CD_IDLE) && fetchValid && !fetchStall &&
         !repeatSingleInstr && (st_q.dbCnt == 2'h0) && !delayedBranch && (|cand);
      st_d.flush = 1'b0;
      st_d.vecRd = 1'b0;
      st_d.push = 1'b0;
      st_d.pcLd = 1'b0;
      st_d.isr = 1'b0;
      // Dispatch sequence; older instructions keep flowing meanwhile
      case (st_q.state)
         CD_IDLE:
         begin
            if (accept)
            begin
               st_d.state = CD_RECOG;
               st_d.ackIdx = cdicLowest(cand);
               st_d.vecIdx = 6'(cdicLowest(cand)) + VEC_OFS;
               st_d.flush = fetchFirst;
               st_d.retAddr = fetchFirst ? fetchAddr : nextFetchAddr;
            end
         end
         CD_RECOG:
         begin
            st_d.state = CD_CLEAR;
         end
         CD_CLEAR:
         begin
            st_d.state = CD_VEC;
            st_d.vecRd = 1'b1;
         end
         CD_VEC:
         begin
            st_d.state = CD_PUSH;
            st_d.push = 1'b1;
         end
         CD_PUSH:
         begin
            st_d.state = CD_FILL1;
            st_d.pcAddr = vecData;
            st_d.pcLd = 1'b1;
         end
         CD_FILL1:
         begin
            st_d.state = CD_FILL2;
         end
         CD_FILL2:
         begin
            st_d.state = CD_FILL3;
         end
         CD_FILL3:
         begin
            st_d.state = CD_EXEC;
            st_d.isr = 1'b1;
         end
         CD_EXEC:
         begin
            st_d.state = CD_IDLE;
         end
         default:
         begin
            st_d.state = CD_IDLE;
         end
      endcase
      // APB answer one cycle after setup
      st_d.rdy = rdEn;
      st_d.err = rdEn && !mapped;
      if (rdEn)
      begin
         case (paddr)
            OFS_FLAG: st_d.rdata = 32'(st_q.flag);
            OFS_ENABLE: st_d.rdata = st_q.ien;
            OFS_STATUS: st_d.rdata = {30'h0, st_q.edgeMode, st_q.global_irq_enable};
            OFS_DMACTL: st_d.rdata = st_q.dmaCtl;
            OFS_PEND: st_d.rdata = 32'(st_q.pend);
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= '0;
         st_q.state <= CD_IDLE;
         st_q.ien <= REG_RST;
         st_q.dmaCtl <= REG_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end
   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = st_q.rdata;
   assign pready = st_q.rdy;
   assign pslverr = st_q.err;
   assign flushFetch = st_q.flush;
   assign vecRdReq = st_q.vecRd;
   assign vecIndex = st_q.vecIdx;
   assign pushReq = st_q.push;
   assign pushData = st_q.retAddr;
   assign pcLoad = st_q.pcLd;
   assign pcLoadAddr = st_q.pcAddr;
   assign isrExec = st_q.isr;
   assign dmaSyncReq = st_q.syncReq;
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_sw_flag_wins: assert property (@(posedge clk) disable iff (!nrst)
      (wrEn && paddr == OFS_FLAG) |=> st_q.flag == $past(pwdata[NUM_FLAGS-1:0]))
      else $error("software flag load lost");
   a_gie_cleared: assert property (@(posedge clk) disable iff (!nrst)
      (st_q.state == CD_RECOG) |=> ##1 !st_q.global_irq_enable)
      else $error("global enable not cleared on take");
   a_isr_latency: assert property (@(posedge clk) disable iff (!nrst)
      (st_q.state == CD_RECOG) |-> ##2 vecRdReq ##1 pushReq ##1 pcLoad ##3 isrExec)
      else $error("dispatch sequence off");
   a_ret_first: assert property (@(posedge clk) disable iff (!nrst)
      (accept && fetchFirst) |=> (flushFetch && pushData == $past(fetchAddr)))
      else $error("first-cycle take wrong");
   a_ret_next: assert property (@(posedge clk) disable iff (!nrst)
      (accept && !fetchFirst) |=> (!flushFetch && pushData == $past(nextFetchAddr)))
      else $error("late-cycle take wrong");
   a_db_block: assert property (@(posedge clk) disable iff (!nrst)
      (delayedBranch || st_q.dbCnt != 2'h0 || repeatSingleInstr) |=>
      st_q.state != CD_RECOG)
      else $error("take in blocked shadow");
   a_stall_hold: assert property (@(posedge clk) disable iff (!nrst)
      (st_q.state == CD_IDLE && (fetchStall || !fetchValid)) |=> st_q.state == CD_IDLE)
      else $error("take while fetch halted");
   a_no_gie_take: assert property (@(posedge clk) disable iff (!nrst)
      (st_q.state == CD_IDLE && !st_q.global_irq_enable) |=> st_q.state == CD_IDLE)
      else $error("take with global enable off");
   a_return_from_irq_gie: assert property (@(posedge clk) disable iff (!nrst)
      (returnFromIrq && st_q.state != CD_CLEAR) |=> st_q.global_irq_enable)
      else $error("return did not set enable");
   a_dma_reset: assert property (@(posedge clk) disable iff (!nrst)
      dmaReset |=> (st_q.pend == '0 && dmaSyncReq == '0))
      else $error("DMA reset left pending latch");
endmodule // cdic_top

// ===== sim/cdic_far_model.sv
`timescale 1ns/1ps
module cdic_far_model
   import cdic_pkg::*;
#(
   parameter int AW = 24,
   parameter int NUM_CH = 2
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Vector table
   input wire logic vecRdReq,
   input wire logic [5:0] vecIndex,
   output logic [AW-1:0] vecData,
   // Memory and DMA
   input wire logic slow,
   input wire logic dummyRdReq,
   output logic dummyRdDone,
   input wire logic [NUM_CH-1:0] dmaSyncReq,
   output logic [NUM_CH-1:0] dmaTaken
);
   logic [2:0] waitQ;
   // ---------------------------------------------------------------
   // Vector valid one cycle after the read, garbage otherwise
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         vecData <= '0;
         waitQ <= '0;
         dummyRdDone <= 1'b0;
         dmaTaken <= '0;
      end
      else
      begin
         vecData <= vecRdReq ? (AW'(24'h00a000) | AW'({vecIndex, 4'h0})) : ~vecData;
         waitQ <= !dummyRdReq ? 3'h0 : (waitQ == 3'h7 ? waitQ : waitQ + 3'h1);
         dummyRdDone <= dummyRdReq && (waitQ == (slow ? 3'h4 : 3'h0));
         dmaTaken <= dmaSyncReq & ~dmaTaken;
      end
   end
endmodule // cdic_far_model

// ===== sim/cdic_top_bench.sv
`timescale 1ns/1ps
module cdic_top_bench
   import cdic_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] paddr = '0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, lastErr;
   logic [31:0] pwdata = '0, prdata;
   logic [3:0] extIrqN = 4'hf, intIrq = '0;
   logic fetchValid = 0, fetchFirst = 0, fetchStall = 0, repeatSingleInstr = 0;
   logic delayedBranch = 0, instrDone = 0, returnFromIrq = 0, condReturnFromIrq = 0;
   logic [23:0] fetchAddr = '0, nextFetchAddr = '0, iackAddr = '0;
   logic [23:0] vecData, pushData, pcLoadAddr, dummyRdAddr;
   logic flushFetch, vecRdReq, pushReq, pcLoad, isrExec, irqAckStrobeN, dummyRdReq;
   logic [5:0] vecIndex;
   logic iackExec = 0, iackExtMem = 0, dummyRdDone, slow = 0, dmaReset = 0;
   logic [1:0] dmaTaken, dmaSyncReq;
   logic [31:0] rdQ[$], pushQ[$], vecQ[$];
   logic [31:0] seed = 32'hd496;
   int numErrors = 0;
   int checked = 0;
   int flushSeen = 0;
   int flushExp = 0;
   cdic_top dut_u (.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .extIrqN, .intIrq, .fetchValid, .fetchFirst, .fetchStall, .repeatSingleInstr,
      .delayedBranch, .instrDone, .fetchAddr, .nextFetchAddr, .returnFromIrq,
      .condReturnFromIrq, .flushFetch, .vecRdReq, .vecIndex, .vecData, .pushReq, .pushData,
      .pcLoad, .pcLoadAddr, .isrExec, .iackExec, .iackExtMem, .iackAddr, .dummyRdDone,
      .irqAckStrobeN, .dummyRdReq, .dummyRdAddr, .dmaReset, .dmaTaken, .dmaSyncReq);
   cdic_far_model far_u (.clk, .nrst, .vecRdReq, .vecIndex, .vecData, .slow, .dummyRdReq,
      .dummyRdDone, .dmaSyncReq, .dmaTaken);
   initial
   begin
      forever #25 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic hang();
      numErrors++;
      tally_and_finish();
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic waitSig(ref logic s, input logic lvl);
      int k;
      k = 0;
      while (s !== lvl)
      begin
         @(posedge clk);
         k++;
         if (k > 60) hang();
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      waitSig(pready, 1'b1);
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] x);
      rdQ.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic dispatch(logic first, logic [5:0] idx);
      logic [23:0] fa, na;
      int n;
      fa = 24'(rnd());
      na = 24'(rnd());
      pushQ.push_back(32'(first ? fa : na));
      vecQ.push_back(32'(24'h00a000 | {idx, 4'h0}));
      flushExp += first;
      @(posedge clk);
      fetchAddr <= fa;
      nextFetchAddr <= na;
      fetchFirst <= first;
      fetchValid <= 1'b1;
      waitSig(vecRdReq, 1'b1);
      fetchValid <= 1'b0;
      chk("vecIndex", 32'(vecIndex), 32'(idx));
      n = 0;
      while (isrExec !== 1'b1)
      begin
         @(posedge clk);
         n++;
         if (n > 20) hang();
      end
      chk("isrLatency", n, 5);
      chk("flushFetch", flushSeen, flushExp);
   endtask
   // ---------------------------------------------------------------
   // Result watcher
   // ---------------------------------------------------------------
   always @(posedge clk)
   begin
      if (psel && penable && pready && !pwrite)
         chk("prdata", prdata, rdQ.size() > 0 ? rdQ.pop_front() : 32'hdead_beef);
      if (flushFetch === 1'b1)
         flushSeen++;
      if (pushReq === 1'b1)
         chk("pushData", 32'(pushData), pushQ.size() > 0 ? pushQ.pop_front() : '1);
      if (pcLoad === 1'b1)
         chk("pcLoadAddr", 32'(pcLoadAddr), vecQ.size() > 0 ? vecQ.pop_front() : '1);
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      logic [31:0] v;
      cyc(12);
      nrst <= 1'b1;
      for (int a = 0; a <= 16; a += 4) rd(8'(a), REG_RST);
      rd(8'h40, 32'h0);
      chk("pslverr", 32'(lastErr), 32'h1);
      v = rnd() & 32'hff;
      wr(OFS_FLAG, v);
      rd(OFS_FLAG, v);
      $display("test registers done");
      for (int m = 0; m < 2; m++)
      begin
         wr(OFS_FLAG, 32'h0);
         wr(OFS_STATUS, 32'(m) << STAT_EDGE_BIT);
         extIrqN[1] <= 1'b0;
         cyc(6);
         rd(OFS_FLAG, 32'h2);
         wr(OFS_FLAG, 32'h0);
         cyc(4);
         rd(OFS_FLAG, m ? 32'h0 : 32'h2);
         extIrqN[1] <= 1'b1;
         cyc(4);
      end
      wr(OFS_STATUS, 32'h0);
      wr(OFS_FLAG, 32'h0);
      extIrqN[2] <= 1'b0;
      cyc(2);
      extIrqN[2] <= 1'b1;
      cyc(4);
      rd(OFS_FLAG, 32'h4);
      wr(OFS_FLAG, 32'h0);
      intIrq[1] <= 1'b1;
      @(posedge clk);
      intIrq[1] <= 1'b0;
      rd(OFS_FLAG, 32'h20);
      $display("test sources done");
      wr(OFS_ENABLE, 32'hff);
      wr(OFS_STATUS, 32'h1);
      wr(OFS_FLAG, 32'h24);
      dispatch(1'b1, 6'h3);
      rd(OFS_FLAG, 32'h20);
      rd(OFS_STATUS, 32'h0);
      fetchValid <= 1'b1;
      cyc(8);
      rd(OFS_FLAG, 32'h20);
      fetchStall <= 1'b1;
      wr(OFS_STATUS, 32'h1);
      cyc(6);
      rd(OFS_FLAG, 32'h20);
      {fetchStall, repeatSingleInstr} <= 2'b01;
      cyc(6);
      rd(OFS_FLAG, 32'h20);
      repeatSingleInstr <= 1'b0;
      delayedBranch <= 1'b1;
      @(posedge clk);
      delayedBranch <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         instrDone <= 1'b1;
         @(posedge clk);
         instrDone <= 1'b0;
         @(posedge clk);
      end
      rd(OFS_FLAG, 32'h20);
      fetchValid <= 1'b0;
      instrDone <= 1'b1;
      @(posedge clk);
      instrDone <= 1'b0;
      dispatch(1'b0, 6'h6);
      for (int r = 0; r < 2; r++)
      begin
         {returnFromIrq, condReturnFromIrq} <= r ? 2'b01 : 2'b10;
         @(posedge clk);
         {returnFromIrq, condReturnFromIrq} <= 2'b00;
         rd(OFS_STATUS, 32'h1);
         wr(OFS_STATUS, 32'h0);
      end
      $display("test dispatch done");
      for (int x = 0; x < 2; x++)
      begin
         slow <= x[0];
         iackAddr <= 24'(rnd());
         iackExtMem <= 1'b1;
         iackExec <= 1'b1;
         @(posedge clk);
         iackExec <= 1'b0;
         waitSig(irqAckStrobeN, 1'b0);
         chk("dummyRdAddr", 32'(dummyRdAddr), 32'(iackAddr));
         chk("dummyRdReq", 32'(dummyRdReq), 32'h1);
         waitSig(irqAckStrobeN, 1'b1);
      end
      iackExtMem <= 1'b0;
      iackExec <= 1'b1;
      @(posedge clk);
      iackExec <= 1'b0;
      cyc(4);
      chk("irqAckStrobeN", 32'(irqAckStrobeN), 32'h1);
      $display("test acknowledge done");
      wr(OFS_ENABLE, 32'h0004_0000);
      wr(OFS_FLAG, 32'h4);
      rd(OFS_FLAG, 32'h4);
      wr(OFS_DMACTL, 32'h1);
      rd(OFS_PEND, 32'h4);
      chk("dmaSyncReq", 32'(dmaSyncReq), 32'h0);
      rd(OFS_FLAG, 32'h0);
      wr(OFS_DMACTL, 32'h8000_0001);
      rd(OFS_PEND, 32'h0);
      wr(OFS_DMACTL, 32'h5);
      wr(OFS_FLAG, 32'h4);
      cyc(2);
      chk("dmaSyncReq", 32'(dmaSyncReq), 32'h1);
      cyc(2);
      rd(OFS_PEND, 32'h0);
      $display("test dma done");
      tally_and_finish();
   end
endmodule // cdic_top_bench
